// ==== common/dtc_pkg.sv ====
package dtc_pkg;
   // Register map, byte addresses
   localparam logic [7:0] DTC_CFG_ADDR  = 8'h00;
   localparam logic [7:0] DTC_STAT_ADDR = 8'h04;
   localparam logic [31:0] DTC_CFG_RST  = 32'h0000_0005;
   // Config field positions
   localparam int DTC_CWL_LSB  = 0;
   localparam int DTC_AL_LSB   = 4;
   localparam int DTC_NOM_LSB  = 9;
   localparam int DTC_WR_LSB   = 12;
   localparam int DTC_KEEP_BIT = 14;
   // Latency offsets in CK cycles
   localparam logic [5:0] DTC_ODTL_SUB = 6'h02;
   localparam logic [5:0] DTC_CWN4_ADD = 6'h04;
   localparam logic [5:0] DTC_CWN8_ADD = 6'h06;
   localparam int DTC_HIST = 32;
   // Asynchronous turn-on/off delay, ps, and its clk cycle window
   localparam int DTC_CLK_PS      = 10000;
   localparam int DTC_AONPD_MIN_PS = 2000;
   localparam int DTC_AONPD_MAX_PS = 8500;
   localparam int DTC_AONPD_MIN_CYC =
      ((DTC_AONPD_MIN_PS + DTC_CLK_PS - 1) / DTC_CLK_PS < 1) ? 1 :
      (DTC_AONPD_MIN_PS + DTC_CLK_PS - 1) / DTC_CLK_PS;
   localparam int DTC_AONPD_MAX_CYC =
      (DTC_AONPD_MAX_PS / DTC_CLK_PS < 1) ? 1 : DTC_AONPD_MAX_PS / DTC_CLK_PS;
   // Refresh cycle time, ps
   localparam int DTC_RFC_PS = 160000;
   localparam int DTC_NSYNC  = 6;

   typedef struct packed {
      logic [16:0] rsvd;
      logic        dll_keep;
      logic [1:0]  rtt_wr;
      logic [2:0]  rtt_nom;
      logic [4:0]  al;
      logic [3:0]  cwl;
   } dtc_cfg_t;

   typedef struct packed {
      logic ck;
      logic odt;
      logic cke;
      logic wr;
      logic bc4;
      logic refr;
   } dtc_pins_t;
endpackage

// ==== hdl/dtc_top.sv ====
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
// Operation
// - Synchronous mode: termination on/off WL-2 CK cycles after ODT sampled.
// - Dynamic ODT: switch to write strength WL-2 cycles after a write.
// - Chop-4 write returns to nominal strength 4+off-latency cycles after write.
// - Length-8 write returns to nominal strength 6+off-latency cycles after write.
// - Turn-off and strength changes land half a CK cycle after counts.
// - Asynchronous mode in precharge power-down when DLL is frozen.
// - Asynchronous mode ignores additive latency.
// - Asynchronous response between 2 ns and 8.5 ns after ODT sampled; the code responds one 10 ns clk cycle after sampling.
// - ODT receiver stays active in power-down; no commands are taken there.
// - With DLL frozen, a transition period surrounds power-down entry.
// - Transition starts WL-1 cycles before first CKE low, start excluded.
// - Transition ends at the included end of the entry delay.
// - Refresh in progress stretches transition to the later refresh end.
// - Assertion in transition may take either sync or async turn-on timing.
// - Deassertion in transition may take either sync or async turn-off timing.
// - Dynamic switching active only when write strength bits are nonzero.
// - Nominal value from three nominal bits, write value from two bits.
// - Synchronous latencies use WL equal CAS write latency plus additive latency.
// - Termination enabled only if nominal or write bits nonzero.
module dtc_top
   import dtc_pkg::*;
#(
   parameter int CK_PS    = 80000,
   parameter int CPDED_CK = 1
)(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ck_pin,
   input  wire logic        odt_pin,
   input  wire logic        cke_pin,
   input  wire logic        wr_pin,
   input  wire logic        bc4_pin,
   input  wire logic        ref_pin,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   output logic      [31:0] rdata,
   output logic             term_on,
   output logic             wr_sel,
   output logic      [2:0]  rtt_code,
   output logic             async_mode,
   output logic             in_xition
);
   localparam int RFC_CK_I = (DTC_RFC_PS + CK_PS - 1) / CK_PS;
   localparam logic [5:0] RFC_CK = RFC_CK_I[5:0];
   localparam logic [5:0] CPDED  = CPDED_CK[5:0];

   dtc_cfg_t  cfg_ff;
   dtc_pins_t raw;
   dtc_pins_t s1_ff;
   dtc_pins_t s2_ff;
   logic                 ck_d_ff;
   logic                 cke_prev_ff;
   logic [DTC_HIST-1:0]  odt_sr_ff;
   logic [DTC_HIST-1:0]  wr_sr_ff;
   logic [DTC_HIST-1:0]  bc_sr_ff;
   logic                 off_pend_ff;
   logic                 cnw_pend_ff;
   logic                 cwn_pend_ff;
   logic [5:0]           rfc_cnt_ff;
   logic [5:0]           xcnt_ff;
   logic                 term_on_ff;
   logic                 wr_sel_ff;
   logic                 async_ff;
   logic                 xition_ff;
   logic [2:0]           code_ff;
   logic [31:0]          rdata_ff;
   logic                 rise;
   logic                 fall;
   logic                 en;
   logic                 dyn_en;
   logic                 wr_ok;
   logic                 on_now;
   logic [5:0]           wl;
   logic [5:0]           odtl;
   logic [4:0]           i_on;
   logic [4:0]           i_c4;
   logic [4:0]           i_c8;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; CK itself is sampled and its edges detected here
   assign raw = '{ck: ck_pin, odt: odt_pin, cke: cke_pin, wr: wr_pin,
                  bc4: bc4_pin, refr: ref_pin};

   genvar g;
   generate
      for (g = 0; g < DTC_NSYNC; g++) begin : g_sync
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               s1_ff[g] <= 1'b0;
               s2_ff[g] <= 1'b0;
            end else begin
               s1_ff[g] <= raw[g];
               s2_ff[g] <= s1_ff[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ck_d_ff <= 1'b0;
      end else begin
         ck_d_ff <= s2_ff.ck;
      end
   end

   assign rise = s2_ff.ck & ~ck_d_ff;
   assign fall = ~s2_ff.ck & ck_d_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode and latencies
   assign en     = (cfg_ff.rtt_nom != 3'h0) || (cfg_ff.rtt_wr != 2'h0);
   assign dyn_en = cfg_ff.rtt_wr != 2'h0;
   assign wl     = 6'(cfg_ff.cwl) + 6'(cfg_ff.al);
   assign odtl   = wl - DTC_ODTL_SUB;
   assign i_on   = 5'(odtl - 6'h01);
   assign i_c4   = 5'(odtl + DTC_CWN4_ADD - 6'h01);
   assign i_c8   = 5'(odtl + DTC_CWN8_ADD - 6'h01);
   // Commands are not decoded while CKE is low
   assign wr_ok  = s2_ff.wr & s2_ff.cke;
   assign on_now = odt_sr_ff[i_on];

   ////////////////////////////////////////////////////////////////////////////
   // Register port
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_ff <= dtc_cfg_t'(DTC_CFG_RST);
      end else if (wr_stb && addr == DTC_CFG_ADDR) begin
         cfg_ff <= dtc_cfg_t'({17'h0_0000, wdata[14:0]});
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_ff <= 32'h0000_0000;
      end else if (rd_stb && addr == DTC_CFG_ADDR) begin
         rdata_ff <= 32'(cfg_ff);
      end else if (rd_stb && addr == DTC_STAT_ADDR) begin
         rdata_ff <= {25'h000_0000, code_ff, xition_ff, async_ff, wr_sel_ff, term_on_ff};
      end else begin
         rdata_ff <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // CK-cycle history of ODT and writes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         odt_sr_ff <= '0;
         wr_sr_ff  <= '0;
         bc_sr_ff  <= '0;
      end else if (rise) begin
         odt_sr_ff <= {odt_sr_ff[DTC_HIST-2:0], s2_ff.odt};
         wr_sr_ff  <= {wr_sr_ff[DTC_HIST-2:0], wr_ok};
         bc_sr_ff  <= {bc_sr_ff[DTC_HIST-2:0], s2_ff.bc4};
      end
   end

   // Changes decided on a rising edge and applied on the next falling edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         off_pend_ff <= 1'b0;
         cnw_pend_ff <= 1'b0;
         cwn_pend_ff <= 1'b0;
      end else if (rise) begin
         off_pend_ff <= ~on_now;
         cnw_pend_ff <= wr_sr_ff[i_on];
         cwn_pend_ff <= (wr_sr_ff[i_c4] & bc_sr_ff[i_c4]) |
                        (wr_sr_ff[i_c8] & ~bc_sr_ff[i_c8]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power-down entry transition and asynchronous mode
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rfc_cnt_ff <= 6'h00;
      end else if (rise && s2_ff.refr && s2_ff.cke) begin
         rfc_cnt_ff <= RFC_CK;
      end else if (rise && rfc_cnt_ff != 6'h00) begin
         rfc_cnt_ff <= rfc_cnt_ff - 6'h01;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cke_prev_ff <= 1'b1;
      end else if (rise) begin
         cke_prev_ff <= s2_ff.cke;
      end
   end

   // The lookback part before CKE low needs no logic: sync response stays legal there
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         xition_ff <= 1'b0;
         async_ff  <= 1'b0;
         xcnt_ff   <= 6'h00;
      end else if (rise) begin
         if (s2_ff.cke || cfg_ff.dll_keep) begin
            xition_ff <= 1'b0;
            async_ff  <= 1'b0;
         end else if (cke_prev_ff) begin
            xition_ff <= 1'b1;
            xcnt_ff   <= (rfc_cnt_ff > CPDED + 6'h01) ? rfc_cnt_ff - 6'h01 : CPDED;
         end else if (xition_ff) begin
            if (xcnt_ff <= 6'h01) begin
               xition_ff <= 1'b0;
               async_ff  <= 1'b1;
            end else begin
               xcnt_ff <= xcnt_ff - 6'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Termination state; transition period keeps the synchronous response
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         term_on_ff <= 1'b0;
      end else if (!en) begin
         term_on_ff <= 1'b0;
      end else if (async_ff) begin
         // One clk stage after sampling fits the 1 to 1 clk cycle window
         term_on_ff <= s2_ff.odt;
      end else if (rise && on_now) begin
         term_on_ff <= 1'b1;
      end else if (fall && off_pend_ff) begin
         term_on_ff <= 1'b0;
      end
   end

   // A new write switch wins over a pending return to nominal
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_sel_ff <= 1'b0;
      end else if (!dyn_en || async_ff) begin
         wr_sel_ff <= 1'b0;
      end else if (fall && cnw_pend_ff) begin
         wr_sel_ff <= 1'b1;
      end else if (fall && cwn_pend_ff) begin
         wr_sel_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         code_ff <= 3'h0;
      end else begin
         code_ff <= wr_sel_ff ? {1'b0, cfg_ff.rtt_wr} : cfg_ff.rtt_nom;
      end
   end

   assign rdata      = rdata_ff;
   assign term_on    = term_on_ff;
   assign wr_sel     = wr_sel_ff;
   assign rtt_code   = code_ff;
   assign async_mode = async_ff;
   assign in_xition  = xition_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   chk_term_disabled: assert property (@(posedge clk) disable iff (rst)
      !en |=> !term_on_ff) else $error("termination on while disabled");
   chk_sync_on: assert property (@(posedge clk) disable iff (rst)
      rise && on_now && en && !async_ff |=> term_on_ff) else $error("sync turn-on missed");
   chk_async_follow: assert property (@(posedge clk) disable iff (rst)
      async_ff && en && $stable(async_ff) |=> term_on_ff == $past(s2_ff.odt))
      else $error("async response not within one cycle");
   chk_cmd_gate: assert property (@(posedge clk) disable iff (rst)
      rise && !s2_ff.cke |=> !wr_sr_ff[0]) else $error("write taken in power-down");
   chk_dyn_off: assert property (@(posedge clk) disable iff (rst)
      !dyn_en |=> !wr_sel_ff) else $error("write strength without dynamic mode");
   chk_off_half: assert property (@(posedge clk) disable iff (rst)
      fall && off_pend_ff && !async_ff |=> !term_on_ff) else $error("turn-off missed");
   chk_cnw_switch: assert property (@(posedge clk) disable iff (rst)
      rise && wr_sr_ff[i_on] && dyn_en && !async_ff ##1 !async_ff[*6]
      |-> wr_sel_ff || !dyn_en) else $error("write strength switch late");
   chk_xition_entry: assert property (@(posedge clk) disable iff (rst)
      rise && cke_prev_ff && !s2_ff.cke && !cfg_ff.dll_keep |=> xition_ff)
      else $error("transition period not started");
   chk_async_cause: assert property (@(posedge clk) disable iff (rst)
      async_ff |-> !cfg_ff.dll_keep && !cke_prev_ff) else $error("async mode without cause");
endmodule // dtc_top

// ==== verification/dtc_ctrl_model.sv ====
`timescale 1ns/1ps
module dtc_ctrl_model
   import dtc_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   output dtc_pins_t pins
);
   logic [1:0] div_ff;
   logic       ck_ff;
   logic       odt_r = 1'b0;
   logic       cke_r = 1'b1;
   logic       wr_r  = 1'b0;
   logic       bc4_r = 1'b0;
   logic       ref_r = 1'b0;
   int         hold  = 0;

   assign pins = {ck_ff, odt_r, cke_r, wr_r, bc4_r, ref_r};

   // Memory CK runs free; eight clk per period gives 80 ns
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_ff <= 2'h0;
         ck_ff  <= 1'b0;
      end else begin
         div_ff <= div_ff + 2'h1;
         if (div_ff == 2'h3) ck_ff <= ~ck_ff;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Pins move at CK fall so every rise samples settled levels
   task automatic step(input logic o, input logic w, input logic b, input logic c,
                       input logic r);
      @(negedge ck_ff);
      if (hold > 0) hold--;
      // An early drop request is overridden, never passed on to the device
      if (!o && odt_r && hold > 0) o = 1'b1;
      if (o && !odt_r) hold = 4;
      if (w && c && o && hold < (b ? 4 : 6)) hold = b ? 4 : 6;
      odt_r <= o;
      cke_r <= c;
      wr_r  <= w && c;
      bc4_r <= b;
      ref_r <= r && c;
   endtask
endmodule // dtc_ctrl_model

// ==== verification/tb_dtc_top.sv ====
`timescale 1ns/1ps
module tb_dtc_top;
   import dtc_pkg::*;
   typedef struct packed {
      logic       bc4;
      logic [5:0] lat;
      logic [5:0] ret;
      dtc_cfg_t   cfg;
   } dtc_row_t;

   logic        clk    = 1'b0;
   logic        rst    = 1'b1;
   logic [7:0]  addr   = 8'h00;
   logic [31:0] wdata  = 32'h0;
   logic        wr_stb = 1'b0;
   logic        rd_stb = 1'b0;
   logic [31:0] rdata;
   logic        term_on;
   logic        wr_sel;
   logic [2:0]  rtt_code;
   logic        async_mode;
   logic        in_xition;
   dtc_pins_t   pins;
   int          fails      = 0;
   int          num_checks = 0;
   // Rows: burst kind, expected on/off latency, expected return latency, config
   dtc_row_t    rows [4] = '{'{1'b1, 6'h03, 6'h07, 32'h0000_1205},
                             '{1'b0, 6'h06, 6'h0c, 32'h0000_2426},
                             '{1'b0, 6'h03, 6'h09, 32'h0000_0605},
                             '{1'b1, 6'h04, 6'h08, 32'h0000_0015}};

   always #5 clk = ~clk;

   dtc_ctrl_model u_ctrl (.clk(clk), .rst(rst), .pins(pins));

   dtc_top #(.CK_PS(80000), .CPDED_CK(1)) u_dut (
      .clk(clk), .rst(rst), .ck_pin(pins.ck), .odt_pin(pins.odt), .cke_pin(pins.cke),
      .wr_pin(pins.wr), .bc4_pin(pins.bc4), .ref_pin(pins.refr), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .term_on(term_on), .wr_sel(wr_sel), .rtt_code(rtt_code),
      .async_mode(async_mode), .in_xition(in_xition));

   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      if (fails == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      chk(rdata, e);
   endtask

   // One CK cycle; sample two clk after the rise, before the design reacts to it
   task automatic tick(input logic o, input logic w, input logic b, input logic c,
                       input logic r);
      u_ctrl.step(o, w, b, c, r);
      @(posedge pins.ck);
      repeat (2) @(posedge clk);
      #1;
   endtask

   initial begin
      #100us;
      fails++;
      summarize();
   end

   ////////////////////////////////////////////////////////////////
   initial begin
      logic en;
      logic ws;
      int   lat;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      reg_rd(DTC_CFG_ADDR, DTC_CFG_RST);
      reg_rd(DTC_STAT_ADDR, 32'h0);
      reg_wr(DTC_STAT_ADDR, 32'hffff_ffff);
      reg_rd(DTC_STAT_ADDR, 32'h0);
      reg_rd(8'h08, 32'h0);
      for (int r = 0; r < 4; r++) begin
         reg_wr(DTC_CFG_ADDR, 32'(rows[r].cfg));
         reg_rd(DTC_CFG_ADDR, 32'(rows[r].cfg));
         en  = |{rows[r].cfg.rtt_nom, rows[r].cfg.rtt_wr};
         lat = int'(rows[r].lat);
         for (int i = 0; i < 16; i++) begin
            tick(i >= 1 && i <= 6, i == 1, rows[r].bc4, 1'b1, 1'b0);
            ws = (|rows[r].cfg.rtt_wr) && i >= 2 + lat && i <= 1 + int'(rows[r].ret);
            chk(term_on, en && i >= 2 + lat && i <= 7 + lat);
            chk(wr_sel, ws);
            chk(rtt_code, ws ? {1'b0, rows[r].cfg.rtt_wr} : rows[r].cfg.rtt_nom);
         end
      end
      // Power-down entry with the DLL frozen, then kept on; AL of 4 would delay sync
      for (int k = 0; k < 2; k++) begin
         reg_wr(DTC_CFG_ADDR, {17'h0, k[0], 14'h0245});
         // Refresh one CK before entry; its end does not outlast the entry delay
         tick(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
         tick(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
         tick(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
         if (k == 0) chk(in_xition, 1'b1);
         tick(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
         chk(in_xition, 1'b0);
         repeat (2) tick(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
         chk(in_xition, 1'b0);
         chk(async_mode, k == 0);
         u_ctrl.step(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
         #1;
         chk(term_on, 1'b0);
         repeat (6) @(posedge clk);
         #1;
         chk(term_on, k == 0);
         chk(wr_sel, 1'b0);
         repeat (3) tick(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
         u_ctrl.step(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
         repeat (6) @(posedge clk);
         #1;
         chk(term_on, 1'b0);
         repeat (14) tick(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
         chk(async_mode, 1'b0);
         chk(term_on, 1'b0);
      end
      summarize();
   end
endmodule // tb_dtc_top
